// File: logic/sram_arb_pkg.sv
/*
  Shared constants and types for the SRAM arbiter and its word memory.
  Assumes a single 100 MHz clock domain with synchronous reset.
*/
package sram_arb_pkg;

  // ****************************************
  // Array geometry
  // ****************************************
  localparam int DATA_W = 32;
  localparam int BE_W   = 4;
  localparam int ADDR_W = 14;
  localparam int DEPTH  = 16384;

  // ****************************************
  // Ownership and reset values
  // ****************************************
  typedef enum logic {OWN_CPU, OWN_AHB} owner_t;

  localparam owner_t     OWNER_RESET       = OWN_CPU;
  localparam logic       BATT_SWITCH_RESET = 1'h1;
  localparam logic       RVALID_RESET      = 1'h0;
  localparam logic       ON_BATT_RESET     = 1'h0;

endpackage

// File: logic/sram_mem_if.sv
/*
  Access channel between the arbiter and the word memory.
  Assumes one access per cycle, read data one cycle after enable.
*/
`timescale 1ns/1ps

interface sram_mem_if;
  logic                              en;
  logic                              we;
  logic [sram_arb_pkg::BE_W-1:0]     be;
  logic [sram_arb_pkg::ADDR_W-1:0]   addr;
  logic [sram_arb_pkg::DATA_W-1:0]   wdata;
  logic [sram_arb_pkg::DATA_W-1:0]   rdata;

  modport arb (output en, we, be, addr, wdata, input rdata);
  modport mem (input en, we, be, addr, wdata, output rdata);
endinterface // sram_mem_if

// File: logic/sram_word_mem.sv
/*
  Single-port 32-bit word array with byte enables and registered read.
  Assumes the arbiter issues at most one access per clock.
*/
`timescale 1ns/1ps

module sram_word_mem (
  // Clock
  input  wire logic   core_clk_in,
  // Access channel
  sram_mem_if.mem     port
);

  logic [sram_arb_pkg::DATA_W-1:0] mem_array [sram_arb_pkg::DEPTH];

  // ****************************************
  // Byte-lane writes
  // ****************************************
  always_ff @(posedge core_clk_in) begin
    for (int b = 0; b < sram_arb_pkg::BE_W; b++) begin
      if (port.en && port.we && port.be[b]) begin
        mem_array[port.addr][b*8 +: 8] <= port.wdata[b*8 +: 8];
      end
    end
  end

  // ****************************************
  // Registered read
  // ****************************************
  always_ff @(posedge core_clk_in) begin
    if (port.en && !port.we) begin
      port.rdata <= mem_array[port.addr];
    end
  end

endmodule // sram_word_mem

// File: logic/sram_dual_port_arbiter.sv
/*
  Shares one 32-bit SRAM between the CPU data coupled port and the AHB
  side, and holds the battery switchover control.
  Assumes each requester holds its request stable until it sees its
  grant high in the same cycle; read data follow one cycle later.
*/
`timescale 1ns/1ps

// How it works
// - One 32-bit array serves the CPU data port with one-cycle reads and writes.
// - AHB masters such as DMA reach the array through the same arbiter path.
// - A sole requester holding the parked grant is served every cycle without waits.
// - When both request, grants alternate one word each so neither starves.
// - With no request the grant stays parked on the most recent user.
// - AHB instruction fetches run without waits while the CPU port is idle, after one switch cycle if the CPU held the grant.
// - A firmware control can stop the SRAM switching onto the battery.
module sram_dual_port_arbiter (
  // Clock and reset
  input  wire logic                              core_clk_in,
  input  wire logic                              srst_in,
  // CPU data coupled port
  input  wire logic                              cpu_req_in,
  input  wire logic                              cpu_we_in,
  input  wire logic [sram_arb_pkg::BE_W-1:0]     cpu_be_in,
  input  wire logic [sram_arb_pkg::ADDR_W-1:0]   cpu_addr_in,
  input  wire logic [sram_arb_pkg::DATA_W-1:0]   cpu_wdata_in,
  output logic                                   cpu_grant_out,
  output logic                                   cpu_rvalid_out,
  output logic      [sram_arb_pkg::DATA_W-1:0]   cpu_rdata_out,
  // AHB side port
  input  wire logic                              ahb_req_in,
  input  wire logic                              ahb_we_in,
  input  wire logic [sram_arb_pkg::BE_W-1:0]     ahb_be_in,
  input  wire logic [sram_arb_pkg::ADDR_W-1:0]   ahb_addr_in,
  input  wire logic [sram_arb_pkg::DATA_W-1:0]   ahb_wdata_in,
  output logic                                   ahb_grant_out,
  output logic                                   ahb_rvalid_out,
  output logic      [sram_arb_pkg::DATA_W-1:0]   ahb_rdata_out,
  // Battery backup control
  input  wire logic                              batt_switch_wr_in,
  input  wire logic                              batt_switch_wdata_in,
  input  wire logic                              main_supply_low_in,
  output logic                                   batt_switch_en_out,
  output logic                                   sram_on_backup_battery_supply_out
);

  sram_mem_if              mem_bus ();
  sram_arb_pkg::owner_t    owner;
  sram_arb_pkg::owner_t    next_owner;
  logic                    cpu_take;
  logic                    ahb_take;

  // ****************************************
  // Arbitration
  // ****************************************
  // parked owner served
  assign cpu_take = cpu_req_in && (owner == sram_arb_pkg::OWN_CPU);
  assign ahb_take = ahb_req_in && (owner == sram_arb_pkg::OWN_AHB);

  // park when the other side is idle
  // Other side's request moves the owner even mid-stream: no starvation
  always_comb begin
    next_owner = owner;
    if (owner == sram_arb_pkg::OWN_CPU && ahb_req_in) begin
      next_owner = sram_arb_pkg::OWN_AHB;
    end else if (owner == sram_arb_pkg::OWN_AHB && cpu_req_in) begin
      next_owner = sram_arb_pkg::OWN_CPU;
    end
  end

  // reset ownership
  // Grant is registered, so a switch of owner costs one cycle; the
  // parked owner never pays it.
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      owner         <= sram_arb_pkg::OWNER_RESET;
      cpu_grant_out <= (sram_arb_pkg::OWNER_RESET == sram_arb_pkg::OWN_CPU);
      ahb_grant_out <= (sram_arb_pkg::OWNER_RESET == sram_arb_pkg::OWN_AHB);
    end else begin
      owner         <= next_owner;
      cpu_grant_out <= (next_owner == sram_arb_pkg::OWN_CPU);
      ahb_grant_out <= (next_owner == sram_arb_pkg::OWN_AHB);
    end
  end

  // ****************************************
  // Shared memory path
  // ****************************************
  // single-cycle array access
  always_comb begin
    mem_bus.en    = cpu_take || ahb_take;
    mem_bus.we    = ahb_take ? ahb_we_in    : cpu_we_in;
    mem_bus.be    = ahb_take ? ahb_be_in    : cpu_be_in;
    mem_bus.addr  = ahb_take ? ahb_addr_in  : cpu_addr_in;
    mem_bus.wdata = ahb_take ? ahb_wdata_in : cpu_wdata_in;
  end

  sram_word_mem u_mem (
    .core_clk_in (core_clk_in),
    .port        (mem_bus.mem)
  );

  // Both ports see the one read register; rvalid says whose it is
  assign cpu_rdata_out = mem_bus.rdata;
  assign ahb_rdata_out = mem_bus.rdata;

  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      cpu_rvalid_out <= sram_arb_pkg::RVALID_RESET;
      ahb_rvalid_out <= sram_arb_pkg::RVALID_RESET;
    end else begin
      cpu_rvalid_out <= cpu_take && !cpu_we_in;
      ahb_rvalid_out <= ahb_take && !ahb_we_in;
    end
  end

  // ****************************************
  // Battery switchover
  // ****************************************
  // firmware switchover control
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      batt_switch_en_out <= sram_arb_pkg::BATT_SWITCH_RESET;
    end else if (batt_switch_wr_in) begin
      batt_switch_en_out <= batt_switch_wdata_in;
    end
  end

  // battery feeds SRAM only when allowed
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      sram_on_backup_battery_supply_out <= sram_arb_pkg::ON_BATT_RESET;
    end else begin
      sram_on_backup_battery_supply_out <= batt_switch_en_out &&
                                           main_supply_low_in;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (srst_in);

  chk_grant_one_hot: assert property (
    cpu_grant_out != ahb_grant_out)
    else $error("grants not one-hot");

  chk_cpu_sole_nowait: assert property (
    cpu_grant_out && cpu_req_in && !ahb_req_in |=> cpu_grant_out)
    else $error("sole cpu requester lost grant");

  chk_ahb_fetch_nowait: assert property (
    (ahb_grant_out && ahb_req_in && !cpu_req_in) [*2] |=> ahb_grant_out)
    else $error("ahb fetch stream stalled");

  chk_contend_alternate: assert property (
    cpu_req_in && ahb_req_in |=> cpu_grant_out != $past(cpu_grant_out))
    else $error("contention did not alternate");

  chk_idle_park: assert property (
    !cpu_req_in && !ahb_req_in |=> $stable(ahb_grant_out))
    else $error("grant moved while idle");

  chk_cpu_read_turn: assert property (
    cpu_req_in && cpu_grant_out && !cpu_we_in |=>
    cpu_rvalid_out && !ahb_rvalid_out)
    else $error("cpu read not one cycle");

  chk_ahb_path_addr: assert property (
    ahb_req_in && ahb_grant_out |->
    mem_bus.en && mem_bus.addr == ahb_addr_in && mem_bus.we == ahb_we_in)
    else $error("ahb access not on memory path");

  chk_batt_gate: assert property (
    !batt_switch_en_out && !batt_switch_wr_in |=>
    !sram_on_backup_battery_supply_out ##1 !sram_on_backup_battery_supply_out)
    else $error("sram on battery while disabled");

  chk_reset_defaults: assert property (
    $past(srst_in) |-> cpu_grant_out && batt_switch_en_out)
    else $error("bad reset defaults");

  chk_ahb_sole_nowait: assert property (
    ahb_grant_out && ahb_req_in && !cpu_req_in |=> ahb_grant_out)
    else $error("sole ahb requester lost grant");

  chk_ahb_read_turn: assert property (
    ahb_req_in && ahb_grant_out && !ahb_we_in |=>
    ahb_rvalid_out && !cpu_rvalid_out)
    else $error("ahb read not one cycle");

  chk_cpu_path_addr: assert property (
    cpu_req_in && cpu_grant_out |->
    mem_bus.en && mem_bus.addr == cpu_addr_in && mem_bus.we == cpu_we_in)
    else $error("cpu access not on memory path");

  chk_write_no_rvalid: assert property (
    cpu_req_in && cpu_grant_out && cpu_we_in |=>
    !cpu_rvalid_out && !ahb_rvalid_out)
    else $error("write raised read valid");

  chk_idle_no_rvalid: assert property (
    !cpu_req_in && !ahb_req_in |=>
    !cpu_rvalid_out && !ahb_rvalid_out)
    else $error("read valid while idle");

  chk_idle_hand_over: assert property (
    cpu_req_in && !ahb_req_in && ahb_grant_out |=> cpu_grant_out)
    else $error("idle owner did not hand over");

  chk_batt_follow: assert property (
    batt_switch_en_out && main_supply_low_in |=>
    sram_on_backup_battery_supply_out)
    else $error("sram not switched to battery");

  chk_batt_write: assert property (
    batt_switch_wr_in |=> batt_switch_en_out == $past(batt_switch_wdata_in))
    else $error("switchover control not loaded");

endmodule // sram_dual_port_arbiter

// File: dv/sram_requester.sv
/*
  Requester model for one arbiter port, CPU data or AHB side.
  Assumes go_in pulses for one cycle per request; go_in held high
  streams one request per granted cycle.
*/
`timescale 1ns/1ps

module sram_requester (
  // Clock and reset
  input  wire logic                            core_clk_in,
  input  wire logic                            srst_in,
  // Bench command
  input  wire logic                            go_in,
  input  wire logic                            we_in,
  input  wire logic [sram_arb_pkg::ADDR_W-1:0] addr_in,
  input  wire logic [sram_arb_pkg::DATA_W-1:0] wdata_in,
  input  wire logic [sram_arb_pkg::BE_W-1:0]   be_in,
  // Arbiter port
  input  wire logic                            grant_in,
  output logic                                 req_out,
  output logic                                 we_out,
  output logic      [sram_arb_pkg::BE_W-1:0]   be_out,
  output logic      [sram_arb_pkg::ADDR_W-1:0] addr_out,
  output logic      [sram_arb_pkg::DATA_W-1:0] wdata_out
);
  // Request held until taken; go still high at a take streams on
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      req_out <= 1'h0;
    end else if (req_out && grant_in) begin
      req_out <= go_in;
    end else if (go_in) begin
      req_out <= 1'h1;
    end
  end
  // Released fields flip, so stale values cannot pass
  always_ff @(posedge core_clk_in) begin
    if (go_in && (!req_out || grant_in)) begin
      we_out    <= we_in;
      be_out    <= be_in;
      addr_out  <= addr_in;
      wdata_out <= wdata_in;
    end else if (req_out && grant_in) begin
      we_out    <= ~we_out;
      be_out    <= ~be_out;
      addr_out  <= ~addr_out;
      wdata_out <= ~wdata_out;
    end
  end
endmodule // sram_requester

// File: dv/sram_dual_port_arbiter_bench.sv
/*
  Self-checking bench for the SRAM arbiter, one model per port.
  Assumes read data one cycle after the taking edge.
*/
`timescale 1ns/1ps

module sram_dual_port_arbiter_bench;
  typedef logic [sram_arb_pkg::DATA_W-1:0] word_t;
  typedef logic [sram_arb_pkg::ADDR_W-1:0] addr_t;
  typedef logic [sram_arb_pkg::BE_W-1:0]   be_t;
  logic  core_clk_in = 1'h0;
  logic  srst_in     = 1'h1;
  logic  c_go = 1'h0, c_we = 1'h0, a_go = 1'h0, a_we = 1'h0;
  logic  b_wr = 1'h0, b_wd = 1'h0, low = 1'h0;
  addr_t c_ad = 14'h0000, a_ad = 14'h0000, c_ao, a_ao;
  word_t c_wd = 32'h0, a_wd = 32'h0, c_wo, a_wo, c_rd, a_rd;
  logic  c_req, c_weo, c_gnt, c_rv, a_req, a_weo, a_gnt, a_rv;
  logic  b_en, b_on;
  be_t   c_be, a_be;
  be_t   c_bi = 4'hF, a_bi = 4'hF;
  int    checked = 0, fail_count = 0;

  always #5 core_clk_in = ~core_clk_in;

  sram_requester u_sram_requester_cpu (.core_clk_in(core_clk_in),
    .srst_in(srst_in), .go_in(c_go), .we_in(c_we), .addr_in(c_ad),
    .wdata_in(c_wd), .be_in(c_bi), .grant_in(c_gnt), .req_out(c_req),
    .we_out(c_weo), .be_out(c_be), .addr_out(c_ao), .wdata_out(c_wo));
  sram_requester u_sram_requester_ahb (.core_clk_in(core_clk_in),
    .srst_in(srst_in), .go_in(a_go), .we_in(a_we), .addr_in(a_ad),
    .wdata_in(a_wd), .be_in(a_bi), .grant_in(a_gnt), .req_out(a_req),
    .we_out(a_weo), .be_out(a_be), .addr_out(a_ao), .wdata_out(a_wo));
  sram_dual_port_arbiter u_sram_dual_port_arbiter (
    .core_clk_in(core_clk_in), .srst_in(srst_in), .cpu_req_in(c_req),
    .cpu_we_in(c_weo), .cpu_be_in(c_be), .cpu_addr_in(c_ao),
    .cpu_wdata_in(c_wo), .cpu_grant_out(c_gnt), .cpu_rvalid_out(c_rv),
    .cpu_rdata_out(c_rd), .ahb_req_in(a_req), .ahb_we_in(a_weo),
    .ahb_be_in(a_be), .ahb_addr_in(a_ao), .ahb_wdata_in(a_wo),
    .ahb_grant_out(a_gnt), .ahb_rvalid_out(a_rv), .ahb_rdata_out(a_rd),
    .batt_switch_wr_in(b_wr), .batt_switch_wdata_in(b_wd),
    .main_supply_low_in(low), .batt_switch_en_out(b_en),
    .sram_on_backup_battery_supply_out(b_on));

  // ****************************************
  // Compare and access helpers
  // ****************************************
  task automatic chk_bit(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_word(input word_t got, input word_t exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // Launch at a falling edge; lat 0 means no read expected
  task automatic go(input logic c, a, we, input addr_t ca, aa,
                    input word_t d, input int cl, al, input word_t ce, ae);
    int cs, as_;
    cs = 0; as_ = 0;
    c_we = we; c_ad = ca; c_wd = d; c_go = c;
    a_we = we; a_ad = aa; a_wd = ~d; a_go = a;
    @(negedge core_clk_in);
    c_go = 1'h0; a_go = 1'h0;
    for (int i = 1; i <= 4; i++) begin
      @(negedge core_clk_in);
      if (c_rv === 1'h1) begin cs = i; chk_word(c_rd, ce); end
      if (a_rv === 1'h1) begin as_ = i; chk_word(a_rd, ae); end
    end
    chk_word(32'(cs), 32'(cl));
    chk_word(32'(as_), 32'(al));
    chk_bit(c_req, 1'h0);
    chk_bit(a_req, 1'h0);
    if (c_req !== 1'h0 || a_req !== 1'h0) begin
      tally_and_finish;
    end
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset;
    chk_bit(c_gnt, 1'h1);
    chk_bit(a_gnt, 1'h0);
    chk_bit(b_en, 1'h1);
    chk_bit(b_on, 1'h0);
    $display("t_reset done");
  endtask
  task automatic t_cpu;
    go(1, 0, 1, 14'h3FFF, 0, 32'hA5C3_0F96, 0, 0, 0, 0);
    go(1, 0, 0, 14'h3FFF, 0, 0, 1, 0, 32'hA5C3_0F96, 0);
    $display("t_cpu done");
  endtask
  task automatic t_ahb;
    go(0, 1, 0, 0, 14'h3FFF, 0, 0, 2, 0, 32'hA5C3_0F96);
    go(0, 1, 1, 0, 14'h0001, 32'h0F0F_1234, 0, 0, 0, 0);
    chk_bit(a_gnt, 1'h1);
    go(0, 1, 0, 0, 14'h0001, 0, 0, 1, 0, 32'hF0F0_EDCB);
    $display("t_ahb done");
  endtask
  task automatic t_both;
    go(1, 1, 0, 14'h0001, 14'h3FFF, 0, 2, 1,
       32'hF0F0_EDCB, 32'hA5C3_0F96);
    chk_bit(c_gnt, 1'h1);
    go(1, 0, 0, 14'h3FFF, 0, 0, 1, 0, 32'hA5C3_0F96, 0);
    go(1, 1, 0, 14'h3FFF, 14'h0001, 0, 1, 2,
       32'hA5C3_0F96, 32'hF0F0_EDCB);
    $display("t_both done");
  endtask
  // AHB stream held three cycles: one word per cycle, no gaps
  task automatic t_fetch;
    logic [7:0] seen;
    seen = 8'h00;
    a_we = 1'h0;
    a_ad = 14'h0001;
    a_go = 1'h1;
    for (int i = 1; i <= 8; i++) begin
      @(negedge core_clk_in);
      if (i == 3) a_go = 1'h0;
      seen[i-1] = a_rv;
      if (a_rv === 1'h1) chk_word(a_rd, 32'hF0F0_EDCB);
    end
    chk_word(32'(seen), 32'h0000_000E);
    chk_bit(a_req, 1'h0);
    $display("t_fetch done");
  endtask
  task automatic t_lanes;
    c_bi = 4'h3;
    go(1, 0, 1, 14'h3FFF, 0, 32'h1111_2222, 0, 0, 0, 0);
    c_bi = 4'hF;
    go(1, 0, 0, 14'h3FFF, 0, 0, 1, 0, 32'hA5C3_2222, 0);
    $display("t_lanes done");
  endtask
  // Reset in mid-run with AHB parked and switchover disabled
  task automatic t_rst_mid;
    go(0, 1, 1, 0, 14'h0002, 32'h0, 0, 0, 0, 0);
    b_wd = 1'h0;
    b_wr = 1'h1;
    @(negedge core_clk_in);
    b_wr = 1'h0;
    chk_bit(a_gnt, 1'h1);
    srst_in = 1'h1;
    repeat (2) @(negedge core_clk_in);
    chk_bit(c_gnt, 1'h1);
    chk_bit(a_gnt, 1'h0);
    chk_bit(b_en, 1'h1);
    chk_bit(b_on, 1'h0);
    srst_in = 1'h0;
    go(1, 0, 0, 14'h0001, 0, 0, 1, 0, 32'hF0F0_EDCB, 0);
    $display("t_rst_mid done");
  endtask
  task automatic t_batt;
    low = 1'h1;
    repeat (3) @(negedge core_clk_in);
    chk_bit(b_on, 1'h1);
    b_wr = 1'h1;
    @(negedge core_clk_in);
    b_wr = 1'h0;
    chk_bit(b_en, 1'h0);
    @(negedge core_clk_in);
    chk_bit(b_on, 1'h0);
    b_wd = 1'h1;
    b_wr = 1'h1;
    @(negedge core_clk_in);
    b_wr = 1'h0;
    chk_bit(b_en, 1'h1);
    @(negedge core_clk_in);
    chk_bit(b_on, 1'h1);
    $display("t_batt done");
  endtask

  initial begin
    repeat (10) @(negedge core_clk_in);
    srst_in = 1'h0;
    t_reset;
    t_cpu;
    t_ahb;
    t_fetch;
    t_both;
    t_lanes;
    t_batt;
    t_rst_mid;
    tally_and_finish;
  end
endmodule // sram_dual_port_arbiter_bench
